//--- mctb_pkg.sv
`default_nettype none
package mctb_pkg;
   // Oscillator periods per multiplex step and per idle gap.
   localparam int unsigned MUX_DIV_10M  = 20000;
   localparam int unsigned MUX_DIV_1M   = 2000;
   localparam int unsigned IDLE_DIV_10M = 2000000;
   localparam int unsigned IDLE_DIV_1M  = 200000;
   localparam int unsigned CNT_W        = 22;
   localparam int unsigned DIGITS       = 8;
   localparam int unsigned DIG_W        = 3;
   localparam logic [DIG_W-1:0] DIGIT_MSD = 3'h7;

   typedef enum logic [2:0] {
      MCTB_MEASURE = 3'h0,
      MCTB_STORE   = 3'h1,
      MCTB_CLEAR   = 3'h2,
      MCTB_IDLE    = 3'h3,
      MCTB_HOLD    = 3'h4
   } mctb_phase_e;

   typedef struct packed {
      logic             store;
      logic             clear;
      logic             measuring;
      logic             holding;
   } mctb_cycle_s;

   typedef struct packed {
      logic [DIG_W-1:0] digit;
      logic             blank_en;
   } mctb_scan_s;
endpackage
`default_nettype wire

//--- mctb_scan.sv
`default_nettype none
// Digit scanner: steps from the most significant digit downward.
module mctb_scan #(
   parameter int unsigned MUX_DIV_HI = mctb_pkg::MUX_DIV_10M,
   parameter int unsigned MUX_DIV_LO = mctb_pkg::MUX_DIV_1M
) (
   input  wire logic                 clk_in,
   input  wire logic                 reset_in,
   input  wire logic                 mode_10m_in,
   input  wire logic                 overflow_in,
   output var  mctb_pkg::mctb_scan_s scan_out,
   output logic                      mux_tick_out
);
   // The divider is sixteen bits wide and needs at least two clocks per
   // multiplex step.
   if (MUX_DIV_HI < 2 || MUX_DIV_LO < 2 ||
       MUX_DIV_HI >= (1 << 16) || MUX_DIV_LO >= (1 << 16)) begin : g_chk_div
      $error("mctb_scan: divider out of range");
   end

   typedef struct packed {
      logic [15:0]                 div;
      logic [mctb_pkg::DIG_W-1:0]  digit;
      logic                        blank_en;
      logic                        tick;
   } mctb_scan_state_s;

   mctb_scan_state_s st_r;
   mctb_scan_state_s st_nxt;
   logic [15:0]      limit;

   always_comb begin
      limit  = mode_10m_in ? 16'(MUX_DIV_HI - 1) : 16'(MUX_DIV_LO - 1);
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      st_nxt.blank_en = ~overflow_in;
      if (st_r.div >= limit) begin
         st_nxt.div  = 16'h0000;
         st_nxt.tick = 1'b1;
         st_nxt.digit = st_r.digit - 3'h1;
      end else begin
         st_nxt.div = st_r.div + 16'h0001;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_r <= '{div: 16'h0000, digit: mctb_pkg::DIGIT_MSD,
                   blank_en: 1'b1, tick: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign scan_out.digit    = st_r.digit;
   assign scan_out.blank_en = st_r.blank_en;
   assign mux_tick_out      = st_r.tick;
endmodule
`default_nettype wire

//--- mctb_timebase.sv
`default_nettype none
// Operation
// - Multiplex step every 20000 (10MHz) or 2000 (1MHz) oscillator periods.
// - Idle gap lasts 2000000 (10MHz) or 200000 (1MHz) oscillator periods.
// - Falling edge of a pause pulse starts a new measurement at once.
// - Pause held high keeps the block in hold; no new measurement.
// - Reset clears counter, aborts measurement, shows all zeros.
// - Digits scan MSD to LSD; overflow disables leading-zero blanking.
module mctb_timebase #(
   parameter int unsigned IDLE_DIV_HI = mctb_pkg::IDLE_DIV_10M,
   parameter int unsigned IDLE_DIV_LO = mctb_pkg::IDLE_DIV_1M,
   parameter int unsigned MUX_DIV_HI  = mctb_pkg::MUX_DIV_10M,
   parameter int unsigned MUX_DIV_LO  = mctb_pkg::MUX_DIV_1M
) (
   input  wire logic                  clk_in,
   input  wire logic                  reset_in,
   input  wire logic                  mode_10m_in,
   input  wire logic                  pause_in,
   input  wire logic                  meas_done_in,
   input  wire logic                  overflow_in,
   output var  mctb_pkg::mctb_cycle_s cycle_out,
   output var  mctb_pkg::mctb_scan_s  scan_out,
   output logic                       mux_tick_out,
   output logic                       show_zero_out
);
   // Elaboration checks. The gap counter is CNT_W bits wide and counts
   // from zero to one less than the gap, so a gap of zero or one that
   // does not fit is refused. The scanner's divider is sixteen bits wide
   // and needs at least two clocks between multiplex steps.
   if (IDLE_DIV_HI < 1 ||
       IDLE_DIV_HI >= (1 << mctb_pkg::CNT_W)) begin : g_chk_idle_hi
      $error("mctb_timebase: IDLE_DIV_HI out of range");
   end
   if (IDLE_DIV_LO < 1 ||
       IDLE_DIV_LO >= (1 << mctb_pkg::CNT_W)) begin : g_chk_idle_lo
      $error("mctb_timebase: IDLE_DIV_LO out of range");
   end
   if (MUX_DIV_HI < 2 || MUX_DIV_HI >= (1 << 16)) begin : g_chk_mux_hi
      $error("mctb_timebase: MUX_DIV_HI out of range");
   end
   if (MUX_DIV_LO < 2 || MUX_DIV_LO >= (1 << 16)) begin : g_chk_mux_lo
      $error("mctb_timebase: MUX_DIV_LO out of range");
   end

   // One measurement cycle runs through the phases in a fixed order.
   //
   //    MEASURE  The counting front end runs until it reports the end.
   //    STORE    One clock. The result latches take the finished count.
   //    CLEAR    One clock. The main counter is cleared for the next run.
   //    IDLE     The gap between measurements, counted in clock periods.
   //    HOLD     Entered from the gap while the pause input is high.
   //
   // The pause input is looked at only in IDLE and HOLD. A pause that
   // arrives during MEASURE, STORE or CLEAR therefore never cuts a
   // measurement short; it takes effect once the gap has begun, and then
   // parks the block in HOLD if it is still high.
   //
   // A falling edge of the pause input seen in the gap ends the gap at
   // once. An outside party can shorten the gap with a short pulse a few
   // clocks after the store strobe: its rise parks the block in HOLD and its fall ends the hold at once. Holding the pause input
   // high parks the block in HOLD after every measurement instead, which gives
   // single-shot operation; a later release of the pause input then starts
   // exactly one new measurement.
   //
   // The gap counter is cleared in CLEAR rather than on the way out of
   // the gap, so every gap starts counting from zero, also one that
   // follows a hold.
   //
   // Reset puts the block into MEASURE with the display forced to zero.
   // The zero flag is cleared by the first store and is set again only
   // by reset, which wins when a store and a reset meet in one clock.
   //
   // The oscillator mode input picks the gap length and the multiplex
   // rate together. It is read on every clock, so a change of mode takes
   // effect in the gap and the multiplex step that are running; a change
   // is best made while the block is held or in reset.

   // All state of the measurement cycle lives in this one struct.
   typedef struct packed {
      // Current phase of the measurement cycle.
      mctb_pkg::mctb_phase_e          phase;
      // Clock periods spent in the present gap.
      logic [mctb_pkg::CNT_W-1:0]     idle_cnt;
      // Pause input one clock ago, for the falling-edge detector.
      logic                           pause_d;
      // High from reset until the first store: the display shows zeros.
      logic                           zero;
      // Registered cycle outputs.
      mctb_pkg::mctb_cycle_s          cyc;
   } mctb_state_s;

   // Registered state and its next value.
   mctb_state_s                st_r;
   mctb_state_s                st_nxt;
   // Last count of the gap in the selected oscillator mode.
   logic [mctb_pkg::CNT_W-1:0] idle_last;
   // Pause seen high on the last clock and low now.
   logic                       pause_fall;

   always_comb begin
      // The gap length follows the oscillator mode input directly.
      idle_last = mode_10m_in ? mctb_pkg::CNT_W'(IDLE_DIV_HI - 1)
                              : mctb_pkg::CNT_W'(IDLE_DIV_LO - 1);
      // The edge detector starts from a low pause input, the idle level
      // of the pin, so leaving reset never shows a false falling edge.
      pause_fall = st_r.pause_d & ~pause_in;

      // Every field holds unless a phase below changes it. Store and
      // clear are single-clock strobes and drop by default.
      st_nxt = st_r;
      st_nxt.pause_d = pause_in;
      st_nxt.cyc.store = 1'b0;
      st_nxt.cyc.clear = 1'b0;

      case (st_r.phase)
         // The front end reports the end of its count; latch the result.
         mctb_pkg::MCTB_MEASURE: begin
            if (meas_done_in) begin
               st_nxt.phase = mctb_pkg::MCTB_STORE;
               st_nxt.cyc.store = 1'b1;
               st_nxt.zero = 1'b0;
            end
         end

         // The latches hold the result now; clear the main counter.
         mctb_pkg::MCTB_STORE: begin
            st_nxt.phase = mctb_pkg::MCTB_CLEAR;
            st_nxt.cyc.clear = 1'b1;
         end

         // Start the gap from a zero count.
         mctb_pkg::MCTB_CLEAR: begin
            st_nxt.phase = mctb_pkg::MCTB_IDLE;
            st_nxt.idle_cnt = '0;
         end

         // Hold wins over the end of the gap, so a pause that rises on
         // the last gap clock still parks the block.
         mctb_pkg::MCTB_IDLE: begin
            st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
            if (pause_in) begin
               st_nxt.phase = mctb_pkg::MCTB_HOLD;
            end else if (pause_fall ||
                         st_r.idle_cnt >= idle_last) begin
               st_nxt.phase = mctb_pkg::MCTB_MEASURE;
            end
         end

         // Leave hold on the first clock that sees the pause input low.
         mctb_pkg::MCTB_HOLD: begin
            if (!pause_in) begin
               st_nxt.phase = mctb_pkg::MCTB_MEASURE;
            end
         end

         // Unused codes fall back into the gap rather than lock up.
         default: st_nxt.phase = mctb_pkg::MCTB_IDLE;
      endcase

      // The level outputs follow the next phase, so they change on the
      // same edge as the phase itself.
      st_nxt.cyc.measuring = (st_nxt.phase == mctb_pkg::MCTB_MEASURE);
      st_nxt.cyc.holding   = (st_nxt.phase == mctb_pkg::MCTB_HOLD);
   end

   // Reset aborts the cycle in progress and forces the display to zero
   // until the first store. The block comes out of reset measuring, so
   // the front end may report the end of a count from the first clock.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_r.phase         <= mctb_pkg::MCTB_MEASURE;
         st_r.idle_cnt      <= '0;
         st_r.pause_d       <= 1'b0;
         st_r.zero          <= 1'b1;
         st_r.cyc.store     <= 1'b0;
         st_r.cyc.clear     <= 1'b0;
         st_r.cyc.measuring <= 1'b1;
         st_r.cyc.holding   <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // The cycle outputs and the zero flag come straight from flip-flops.
   assign cycle_out     = st_r.cyc;
   assign show_zero_out = st_r.zero;

   // The digit scanner runs free of the measurement cycle. It steps
   // from the most significant digit down at the multiplex rate of the
   // selected oscillator mode, and it turns leading-zero blanking off
   // while the main counter reports an overflow. Reset starts it again
   // at the most significant digit with a fresh divider count.
   mctb_scan #(
      .MUX_DIV_HI (MUX_DIV_HI),
      .MUX_DIV_LO (MUX_DIV_LO)
   ) u_scan (
      .clk_in       (clk_in),
      .reset_in     (reset_in),
      .mode_10m_in  (mode_10m_in),
      .overflow_in  (overflow_in),
      .scan_out     (scan_out),
      .mux_tick_out (mux_tick_out)
   );
endmodule
`default_nettype wire

//--- mctb_asserts.sv
`default_nettype none
module mctb_chk #(
   parameter int unsigned IDLE_DIV_HI = mctb_pkg::IDLE_DIV_10M,
   parameter int unsigned IDLE_DIV_LO = mctb_pkg::IDLE_DIV_1M,
   parameter int unsigned MUX_DIV_HI  = mctb_pkg::MUX_DIV_10M,
   parameter int unsigned MUX_DIV_LO  = mctb_pkg::MUX_DIV_1M
) (
   input wire logic                  clk_in,
   input wire logic                  reset_in,
   input wire logic                  mode_10m_in,
   input wire logic                  pause_in,
   input wire logic                  meas_done_in,
   input wire logic                  overflow_in,
   input wire mctb_pkg::mctb_cycle_s cycle_out,
   input wire mctb_pkg::mctb_scan_s  scan_out,
   input wire logic                  mux_tick_out,
   input wire logic                  show_zero_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clocks since the last store while neither measuring nor holding,
   // and clocks since the last multiplex step.
   int unsigned idle_run_r;
   int unsigned tick_gap_r;
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         idle_run_r <= 32'h0000_0000;
         tick_gap_r <= 32'h0000_0000;
      end else begin
         idle_run_r <= (cycle_out.store || cycle_out.measuring ||
                        cycle_out.holding) ? 32'h0000_0000
                                           : idle_run_r + 32'h0000_0001;
         tick_gap_r <= mux_tick_out ? 32'h0000_0001
                                    : tick_gap_r + 32'h0000_0001;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   chk_store_after_done: assert property (
      cycle_out.measuring && meas_done_in |=> cycle_out.store)
      else $error("store missing");
   chk_clear_after_store: assert property (
      cycle_out.store |=> cycle_out.clear && !cycle_out.measuring)
      else $error("clear missing");
   chk_idle_bounded: assert property (
      idle_run_r <= (mode_10m_in ? IDLE_DIV_HI : IDLE_DIV_LO) + 1)
      else $error("idle too long");
   chk_mux_period: assert property (
      mux_tick_out |->
      tick_gap_r == (mode_10m_in ? MUX_DIV_HI : MUX_DIV_LO))
      else $error("mux period");
   chk_digit_down: assert property (
      $changed(scan_out.digit) |->
      scan_out.digit == $past(scan_out.digit) - 3'h1)
      else $error("digit order");
   chk_blank_ovf: assert property (
      !$past(reset_in) |-> scan_out.blank_en == !$past(overflow_in))
      else $error("blanking");
   chk_hold_stays: assert property (
      cycle_out.holding && pause_in |=> cycle_out.holding)
      else $error("hold lost");
   chk_pause_start: assert property (
      cycle_out.holding && !pause_in |=> cycle_out.measuring)
      else $error("no restart");
   chk_zero_reset: assert property (
      $past(reset_in) |-> show_zero_out && cycle_out.measuring)
      else $error("reset state");
endmodule
bind mctb_timebase mctb_chk #(
   .IDLE_DIV_HI (IDLE_DIV_HI),
   .IDLE_DIV_LO (IDLE_DIV_LO),
   .MUX_DIV_HI  (MUX_DIV_HI),
   .MUX_DIV_LO  (MUX_DIV_LO)
) u_chk (
   .clk_in(clk_in), .reset_in(reset_in), .mode_10m_in(mode_10m_in),
   .pause_in(pause_in), .meas_done_in(meas_done_in),
   .overflow_in(overflow_in), .cycle_out(cycle_out),
   .scan_out(scan_out), .mux_tick_out(mux_tick_out),
   .show_zero_out(show_zero_out));
`default_nettype wire

//--- mctb_panel.sv
`default_nettype none
// Panel model: 0 idle, 1 short pulse after store, 2 hold high.
module mctb_panel (
   input  wire logic       clk_in,
   input  wire logic       store_in,
   input  wire logic [1:0] sel_in,
   output logic            pause_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] sh_r    = 4'h0;
   logic       pause_r = 1'b0;
   // Rising-edge updates by non-blocking assignment: the selection, which
   // the bench changes on the falling edge, is settled when it is read.
   always @(posedge clk_in) begin
      sh_r    <= {sh_r[2:0], store_in};
      pause_r <= (sel_in == 2'h1) ? sh_r[3] : (sel_in == 2'h2);
   end
   assign pause_out = pause_r;
endmodule
`default_nettype wire

//--- testbench.sv
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
err_count++; $display("[ERR] %0t mismatch", $time); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // Shortened dividers keep the run brief.
   localparam int unsigned IDLE_HI = 20;
   localparam int unsigned IDLE_LO = 10;
   localparam int unsigned MUX_HI  = 8;
   localparam int unsigned MUX_LO  = 4;
   logic                  clk_in   = 1'b0;
   logic                  reset_in = 1'b1;
   logic                  mode     = 1'b0;
   logic                  done     = 1'b0;
   logic                  ovf      = 1'b0;
   logic                  pause;
   logic [1:0]            psel     = 2'h0;
   mctb_pkg::mctb_cycle_s cyc;
   mctb_pkg::mctb_scan_s  scan;
   logic                  tick;
   logic                  zero;
   logic [2:0]            dig;
   int                    err_count       = 0;
   int                    samples_checked = 0;
   int                    n;
   always #12.5 clk_in = ~clk_in;
   mctb_timebase #(
      .IDLE_DIV_HI (IDLE_HI),
      .IDLE_DIV_LO (IDLE_LO),
      .MUX_DIV_HI  (MUX_HI),
      .MUX_DIV_LO  (MUX_LO)
   ) u_dut (
      .clk_in        (clk_in),
      .reset_in      (reset_in),
      .mode_10m_in   (mode),
      .pause_in      (pause),
      .meas_done_in  (done),
      .overflow_in   (ovf),
      .cycle_out     (cyc),
      .scan_out      (scan),
      .mux_tick_out  (tick),
      .show_zero_out (zero)
   );
   mctb_panel u_panel (
      .clk_in    (clk_in),
      .store_in  (cyc.store),
      .sel_in    (psel),
      .pause_out (pause)
   );
   task automatic rst(input logic m);
      reset_in = 1;
      mode = m;
      repeat (6) @(negedge clk_in);
      reset_in = 0;
      `CHK(zero, 1'b1)
      `CHK(scan.digit, mctb_pkg::DIGIT_MSD)
   endtask
   task automatic run(input logic [1:0] s);
      psel = s;
      @(negedge clk_in) done = 1;
      @(negedge clk_in) done = 0;
      `CHK({cyc.store, cyc.measuring, zero}, 3'h4)
      @(negedge clk_in) `CHK(cyc.clear, 1'b1)
      n = 0;
      while (cyc.measuring !== 1'b1 && n < 60) begin
         @(negedge clk_in) n++;
      end
   endtask
   task automatic t_gap;
      run(2'h0);
      `CHK(n, (mode ? IDLE_HI : IDLE_LO) + 1)
   endtask
   task automatic t_short;
      run(2'h1);
      `CHK(n < 8, 1'b1)
   endtask
   task automatic t_hold;
      run(2'h2);
      `CHK({cyc.holding, cyc.measuring}, 2'h2)
      psel = 2'h0;
      repeat (2) @(negedge clk_in);
      `CHK(cyc.measuring, 1'b1)
   endtask
   task automatic t_ovf;
      ovf = 1'b1;
      repeat (2) @(negedge clk_in);
      `CHK(scan.blank_en, 1'b0)
      ovf = 1'b0;
      repeat (2) @(negedge clk_in);
      `CHK(scan.blank_en, 1'b1)
   endtask
   task automatic t_scan(input int unsigned div);
      n = 0;
      while (tick !== 1'b1 && n < 40) begin
         @(negedge clk_in) n++;
      end
      dig = scan.digit;
      n = 0;
      do begin
         @(negedge clk_in) n++;
      end while (tick !== 1'b1 && n < 40);
      `CHK(n, div)
      `CHK(scan.digit, 3'(dig - 3'h1))
   endtask
   task automatic finish_test;
      if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      rst(1'b0);
      t_gap();
      t_short();
      t_hold();
      t_ovf();
      t_scan(MUX_LO);
      rst(1'b1);
      t_gap();
      t_scan(MUX_HI);
      finish_test;
   end
   // The tests need under two hundred clocks; this allows about ten times that.
   initial begin
      #50000;
      err_count++;
      finish_test;
   end
endmodule
`default_nettype wire
